/* File: rtl/rvc_pkg.sv */
// Shared constants and types of the restore-value command path, host end and device end.
package rvc_pkg;

  // Command codes.
  localparam logic [7:0] RVC_CMD_RESTORE  = 8'h0E;
  localparam logic [7:0] RVC_CMD_TRANSFER = 8'h0F;

  // Parameter list layout in bytes.
  localparam int         RVC_PRM_BYTES     = 8;
  localparam int         RVC_KEY_BYTES     = 6;
  localparam logic [2:0] RVC_PRM_BLOCK_OFS = 3'h0;
  localparam logic [2:0] RVC_PRM_SEL_OFS   = 3'h1;
  localparam logic [2:0] RVC_PRM_KEY_OFS   = 3'h2;
  localparam logic [2:0] RVC_PRM_LAST_SHORT = 3'h1;
  localparam logic [2:0] RVC_PRM_LAST_LONG  = 3'h7;

  // Key selector fields.
  localparam int         RVC_SEL_KEYB_BIT   = 7;
  localparam int         RVC_SEL_INLINE_BIT = 6;
  localparam int         RVC_KEYNUM_W       = 6;
  localparam int         RVC_KEY_COUNT      = 40;
  localparam logic [5:0] RVC_KEYNUM_MAX     = 6'h27;

  // Result codes returned to the host.
  localparam logic [7:0] RVC_RES_OK       = 8'h00;
  localparam logic [7:0] RVC_RES_AUTH_ERR = 8'h01;
  localparam logic [7:0] RVC_RES_FMT_ERR  = 8'h02;
  localparam logic [7:0] RVC_RES_KEY_ERR  = 8'h03;
  localparam logic [7:0] RVC_RES_TAG_ERR  = 8'h04;
  localparam logic [7:0] RVC_RES_UNSUPP   = 8'h05;
  localparam logic [7:0] RVC_RES_RESET    = 8'h00;

  // Operations requested from the tag engine.
  typedef enum logic [1:0] {
    RVC_OP_AUTH    = 2'b00,
    RVC_OP_CHECK   = 2'b01,
    RVC_OP_RESTORE = 2'b10
  } rvc_tag_op_type;

  // Device sequencer states.
  typedef enum logic [2:0] {
    RVC_D_IDLE    = 3'b000,
    RVC_D_AUTH    = 3'b001,
    RVC_D_CHECK   = 3'b010,
    RVC_D_RESTORE = 3'b011,
    RVC_D_ANSWER  = 3'b100
  } rvc_dev_state_type;

  // Host sequencer states.
  typedef enum logic [2:0] {
    RVC_H_IDLE  = 3'b000,
    RVC_H_PARAM = 3'b001,
    RVC_H_CMD   = 3'b010,
    RVC_H_WAIT  = 3'b011,
    RVC_H_DONE  = 3'b100
  } rvc_host_state_type;

endpackage

/* File: rtl/rvc_if.sv */
// Command interface joining the host end and the device end.
interface rvc_if (
  input wire logic i_ref_clk,
  input wire logic i_resetn
);
  logic       prm_we;
  logic [2:0] prm_idx;
  logic [7:0] prm_data;
  logic       cmd_we;
  logic [7:0] cmd_code;
  logic       busy;
  logic       rsp_valid;
  logic [7:0] rsp_result;

  modport host_mp (
    input  i_ref_clk, i_resetn, busy, rsp_valid, rsp_result,
    output prm_we, prm_idx, prm_data, cmd_we, cmd_code
  );

  modport dev_mp (
    input  i_ref_clk, i_resetn, prm_we, prm_idx, prm_data, cmd_we, cmd_code,
    output busy, rsp_valid, rsp_result
  );
endinterface

/* File: rtl/rvc_device.sv */
// Device end: restore-value command sequencer between the command interface and the tag engine.
module rvc_device (
  rvc_if.dev_mp                     bus,
  input  wire logic                 i_key_we,
  input  wire logic [5:0]           i_key_idx,
  input  wire logic [47:0]          i_key_data,
  input  wire logic                 i_tag_done,
  input  wire logic                 i_tag_ok,
  output logic                      o_tag_req,
  output rvc_pkg::rvc_tag_op_type   o_tag_op,
  output logic [7:0]                o_tag_block,
  output logic [47:0]               o_tag_key,
  output logic                      o_tag_key_b
);
  import rvc_pkg::*;

  logic [7:0]        prm_q [RVC_PRM_BYTES];
  logic [47:0]       key_mem [RVC_KEY_COUNT];
  rvc_dev_state_type state_q;
  logic              busy_q;
  logic              rsp_valid_q;
  logic [7:0]        result_q;
  logic              tag_req_q;
  rvc_tag_op_type    tag_op_q;
  logic [7:0]        block_q;
  logic [47:0]       key_q;
  logic              key_b_q;
  logic [7:0]        sel;
  logic [5:0]        keynum;
  logic [47:0]       inline_key;
  logic [47:0]       stored_key;
  logic              keynum_bad;
  logic [7:0]        pend_q;
  logic              cmd_take;
  logic              cmd_ok;
  logic              key_ok;

  // Interface and tag outputs are plain flop copies.
  assign bus.busy       = busy_q;
  assign bus.rsp_valid  = rsp_valid_q;
  assign bus.rsp_result = result_q;
  assign o_tag_req      = tag_req_q;
  assign o_tag_op       = tag_op_q;
  assign o_tag_block    = block_q;
  assign o_tag_key      = key_q;
  assign o_tag_key_b    = key_b_q;

  // Parameter bytes are frozen while a command runs so the key cannot change under it.
  always_ff @(posedge bus.i_ref_clk or negedge bus.i_resetn) begin
    if (!bus.i_resetn) begin
      for (int i = 0; i < RVC_PRM_BYTES; i++) begin
        prm_q[i] <= 8'h00;
      end
    end else if (bus.prm_we && !busy_q) begin
      prm_q[bus.prm_idx] <= bus.prm_data;
    end
  end

  // Key storage has no reset; software loads it before the first command.
  always_ff @(posedge bus.i_ref_clk) begin
    if (i_key_we && (i_key_idx <= RVC_KEYNUM_MAX)) begin
      key_mem[i_key_idx] <= i_key_data;
    end
  end

  // Decode of the selector byte and assembly of the inline key.
  assign sel        = prm_q[RVC_PRM_SEL_OFS];
  assign keynum     = sel[RVC_KEYNUM_W-1:0];
  assign keynum_bad = (keynum > RVC_KEYNUM_MAX);
  assign stored_key = keynum_bad ? 48'h0000_0000_0000 : key_mem[keynum];

  // The byte at the key offset is the least significant one.
  always_comb begin
    inline_key = 48'h0000_0000_0000;
    for (int i = 0; i < RVC_KEY_BYTES; i++) begin
      inline_key[8*i +: 8] = prm_q[int'(RVC_PRM_KEY_OFS) + i];
    end
  end

  // Commands are taken only while idle; one that arrives during a run is dropped rather
  // than queued, which keeps the sequencer free of any backlog.
  assign cmd_take = (state_q == RVC_D_IDLE) && bus.cmd_we;
  assign cmd_ok   = (bus.cmd_code == RVC_CMD_RESTORE);
  assign key_ok   = sel[RVC_SEL_INLINE_BIT] || !keynum_bad;

  // Sequencer: authenticate, check the value format, restore, then answer.
  always_ff @(posedge bus.i_ref_clk or negedge bus.i_resetn) begin
    if (!bus.i_resetn) begin
      state_q <= RVC_D_IDLE;
    end else begin
      unique case (state_q)
        RVC_D_IDLE: begin
          if (cmd_take) begin
            state_q <= (cmd_ok && key_ok) ? RVC_D_AUTH : RVC_D_ANSWER;
          end
        end
        RVC_D_AUTH: begin
          if (i_tag_done) begin
            state_q <= i_tag_ok ? RVC_D_CHECK : RVC_D_ANSWER;
          end
        end
        RVC_D_CHECK: begin
          // A block that fails the format check is never handed to the restore step.
          if (i_tag_done) begin
            state_q <= i_tag_ok ? RVC_D_RESTORE : RVC_D_ANSWER;
          end
        end
        RVC_D_RESTORE: begin
          // No write-back follows; persisting the value is the host's job.
          if (i_tag_done) begin
            state_q <= RVC_D_ANSWER;
          end
        end
        RVC_D_ANSWER: begin
          state_q <= RVC_D_IDLE;
        end
        default: begin
          state_q <= RVC_D_IDLE;
        end
      endcase
    end
  end

  // Busy covers the whole run and falls on the edge that raises the answer strobe.
  always_ff @(posedge bus.i_ref_clk or negedge bus.i_resetn) begin
    if (!bus.i_resetn) begin
      busy_q      <= 1'b0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= (state_q == RVC_D_ANSWER);
      if (cmd_take) begin
        busy_q <= 1'b1;
      end else if ((state_q == RVC_D_ANSWER) || (state_q == RVC_D_IDLE)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // The outcome waits in a side register and is shown together with the answer strobe,
  // so the result the host sees never changes between two answers.
  always_ff @(posedge bus.i_ref_clk or negedge bus.i_resetn) begin
    if (!bus.i_resetn) begin
      pend_q   <= RVC_RES_RESET;
      result_q <= RVC_RES_RESET;
    end else begin
      if (state_q == RVC_D_ANSWER) begin
        result_q <= pend_q;
      end
      unique case (state_q)
        RVC_D_IDLE: begin
          if (cmd_take && !cmd_ok) begin
            pend_q <= RVC_RES_UNSUPP;
          end else if (cmd_take && !key_ok) begin
            pend_q <= RVC_RES_KEY_ERR;
          end
        end
        RVC_D_AUTH: begin
          if (i_tag_done && !i_tag_ok) begin
            pend_q <= RVC_RES_AUTH_ERR;
          end
        end
        RVC_D_CHECK: begin
          if (i_tag_done && !i_tag_ok) begin
            pend_q <= RVC_RES_FMT_ERR;
          end
        end
        RVC_D_RESTORE: begin
          if (i_tag_done) begin
            pend_q <= i_tag_ok ? RVC_RES_OK : RVC_RES_TAG_ERR;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // One request pulse per tag step; block and key are latched once, at the start of a run.
  always_ff @(posedge bus.i_ref_clk or negedge bus.i_resetn) begin
    if (!bus.i_resetn) begin
      tag_req_q <= 1'b0;
      tag_op_q  <= RVC_OP_AUTH;
      block_q   <= 8'h00;
      key_q     <= 48'h0000_0000_0000;
      key_b_q   <= 1'b0;
    end else begin
      tag_req_q <= 1'b0;
      unique case (state_q)
        RVC_D_IDLE: begin
          if (cmd_take && cmd_ok && key_ok) begin
            block_q   <= prm_q[RVC_PRM_BLOCK_OFS];
            key_q     <= sel[RVC_SEL_INLINE_BIT] ? inline_key : stored_key;
            key_b_q   <= sel[RVC_SEL_KEYB_BIT];
            tag_op_q  <= RVC_OP_AUTH;
            tag_req_q <= 1'b1;
          end
        end
        RVC_D_AUTH: begin
          if (i_tag_done && i_tag_ok) begin
            tag_op_q  <= RVC_OP_CHECK;
            tag_req_q <= 1'b1;
          end
        end
        RVC_D_CHECK: begin
          if (i_tag_done && i_tag_ok) begin
            tag_op_q  <= RVC_OP_RESTORE;
            tag_req_q <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule

/* File: rtl/rvc_host.sv */
// Host end: writes the parameter list, issues restore and optionally the follow-up transfer.
module rvc_host (
  rvc_if.host_mp        bus,
  input  wire logic     i_start,
  input  wire logic [7:0] i_block,
  input  wire logic [7:0] i_key_sel,
  input  wire logic [47:0] i_key,
  input  wire logic     i_persist,
  input  wire logic [7:0] i_dest_block,
  output logic          o_busy,
  output logic          o_done,
  output logic [7:0]    o_result,
  output logic          o_restored
);
  import rvc_pkg::*;

  rvc_host_state_type state_q;
  logic [2:0]  idx_q;
  logic        phase_q;
  logic [7:0]  block_q;
  logic [7:0]  dest_q;
  logic [7:0]  sel_q;
  logic [47:0] key_q;
  logic        persist_q;
  logic        prm_we_q;
  logic [2:0]  prm_idx_q;
  logic [7:0]  prm_data_q;
  logic        cmd_we_q;
  logic [7:0]  cmd_code_q;
  logic        busy_q;
  logic        done_q;
  logic [7:0]  result_q;
  logic        restored_q;
  logic [2:0]  last_idx;
  logic [7:0]  byte_now;

  assign bus.prm_we   = prm_we_q;
  assign bus.prm_idx  = prm_idx_q;
  assign bus.prm_data = prm_data_q;
  assign bus.cmd_we   = cmd_we_q;
  assign bus.cmd_code = cmd_code_q;
  assign o_busy       = busy_q;
  assign o_done       = done_q;
  assign o_result     = result_q;
  assign o_restored   = restored_q;

  // Inline key bytes are sent only when the selector asks for them.
  assign last_idx = sel_q[RVC_SEL_INLINE_BIT] ? RVC_PRM_LAST_LONG : RVC_PRM_LAST_SHORT;

  // Byte for the current parameter offset; key goes least significant first.
  always_comb begin
    byte_now = 8'h00;
    if (idx_q == RVC_PRM_BLOCK_OFS) begin
      byte_now = phase_q ? dest_q : block_q;
    end else if (idx_q == RVC_PRM_SEL_OFS) begin
      byte_now = sel_q;
    end else begin
      byte_now = key_q[8*(idx_q - RVC_PRM_KEY_OFS) +: 8];
    end
  end

  // Sequencer for one restore and, when asked, the transfer that makes it persistent.
  always_ff @(posedge bus.i_ref_clk or negedge bus.i_resetn) begin
    if (!bus.i_resetn) begin
      state_q    <= RVC_H_IDLE;
      idx_q      <= 3'h0;
      phase_q    <= 1'b0;
      block_q    <= 8'h00;
      dest_q     <= 8'h00;
      sel_q      <= 8'h00;
      key_q      <= 48'h0000_0000_0000;
      persist_q  <= 1'b0;
      prm_we_q   <= 1'b0;
      prm_idx_q  <= 3'h0;
      prm_data_q <= 8'h00;
      cmd_we_q   <= 1'b0;
      cmd_code_q <= 8'h00;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      result_q   <= RVC_RES_RESET;
      restored_q <= 1'b0;
    end else begin
      prm_we_q <= 1'b0;
      cmd_we_q <= 1'b0;
      done_q   <= 1'b0;
      unique case (state_q)
        RVC_H_IDLE: begin
          if (i_start) begin
            block_q    <= i_block;
            dest_q     <= i_dest_block;
            sel_q      <= i_key_sel;
            key_q      <= i_key;
            persist_q  <= i_persist;
            phase_q    <= 1'b0;
            idx_q      <= 3'h0;
            busy_q     <= 1'b1;
            restored_q <= 1'b0;
            state_q    <= RVC_H_PARAM;
          end
        end
        RVC_H_PARAM: begin
          // The device drops parameter writes while busy, so wait it out.
          if (!bus.busy) begin
            prm_we_q   <= 1'b1;
            prm_idx_q  <= idx_q;
            prm_data_q <= byte_now;
            idx_q      <= idx_q + 3'h1;
            if (idx_q == last_idx) begin
              state_q <= RVC_H_CMD;
            end
          end
        end
        RVC_H_CMD: begin
          cmd_we_q   <= 1'b1;
          cmd_code_q <= phase_q ? RVC_CMD_TRANSFER : RVC_CMD_RESTORE;
          state_q    <= RVC_H_WAIT;
        end
        RVC_H_WAIT: begin
          if (bus.rsp_valid) begin
            result_q <= bus.rsp_result;
            if (!phase_q && (bus.rsp_result == RVC_RES_OK)) begin
              restored_q <= 1'b1;
            end
            if (!phase_q && persist_q && (bus.rsp_result == RVC_RES_OK)) begin
              phase_q <= 1'b1;
              idx_q   <= 3'h0;
              state_q <= RVC_H_PARAM;
            end else begin
              state_q <= RVC_H_DONE;
            end
          end
        end
        RVC_H_DONE: begin
          done_q  <= 1'b1;
          busy_q  <= 1'b0;
          state_q <= RVC_H_IDLE;
        end
        default: begin
          busy_q  <= 1'b0;
          state_q <= RVC_H_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: test/rvc_cmd_sva.sv */
// Protocol checker for the command interface between the host end and the device end.
module rvc_cmd_sva (
  input wire logic       i_ref_clk,
  input wire logic       i_resetn,
  input wire logic       prm_we,
  input wire logic [2:0] prm_idx,
  input wire logic [7:0] prm_data,
  input wire logic       cmd_we,
  input wire logic [7:0] cmd_code,
  input wire logic       busy,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_result
);
  timeunit 1ns;
  timeprecision 1ps;
  import rvc_pkg::*;

  // All checks share the one reference clock and its reset.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  chk_cmd_sets_busy: assert property (cmd_we && !busy |=> busy)
    else $error("busy did not rise after a command was taken");
  chk_unsupp_answer: assert property (cmd_we && !busy && cmd_code != 8'h0E
    |=> busy ##1 (rsp_valid && rsp_result == 8'h05))
    else $error("non-restore code not answered as unsupported");
  chk_answer_ends_cmd: assert property (rsp_valid |-> !busy && $past(busy))
    else $error("answer not at the end of a busy command");
  chk_answer_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer strobe longer than one cycle");
  chk_result_holds: assert property (!rsp_valid |-> $stable(rsp_result))
    else $error("result changed without an answer");
  chk_block_first: assert property (prm_we && prm_idx == 3'h1
    |-> $past(prm_we) && $past(prm_idx) == 3'h0)
    else $error("selector byte not preceded by block byte");
  chk_short_list: assert property (prm_we && prm_idx == 3'h1 && !prm_data[6]
    |=> cmd_we && !prm_we)
    else $error("stored-key list not ended after the selector");
  chk_inline_start: assert property (prm_we && prm_idx == 3'h1 && prm_data[6]
    |=> prm_we && prm_idx == 3'h2)
    else $error("inline key bytes do not follow the selector");
  chk_inline_order: assert property (prm_we && prm_idx >= 3'h2 && prm_idx < 3'h7
    |=> prm_we && prm_idx == $past(prm_idx) + 3'h1)
    else $error("inline key bytes out of order");
  chk_transfer_after_ok: assert property (cmd_we && cmd_code == 8'h0F
    |-> rsp_result == 8'h00 && $past(prm_we))
    else $error("transfer issued without a successful restore");
endmodule

/* File: test/testbench.sv */
// Self-checking bench joining host end and device end, with a behavioural tag engine.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rvc_pkg::*;

  logic i_ref_clk = 1'b0, i_resetn = 1'b0;
  logic i_key_we = 1'b0, i_tag_done = 1'b0, i_tag_ok = 1'b0;
  logic [5:0] i_key_idx = 6'h00;
  logic [47:0] i_key_data = 48'h0, i_key = 48'h0, o_tag_key;
  logic i_start = 1'b0, i_persist = 1'b0, o_busy, o_done, o_restored, o_tag_req, o_tag_key_b;
  logic [7:0] i_block = 8'h00, i_key_sel = 8'h00, i_dest_block = 8'h00, o_result, o_tag_block;
  rvc_tag_op_type o_tag_op, fail_op = RVC_OP_AUTH;
  logic fail_en = 1'b0;
  logic [5:0] ops_seen;
  logic [1:0] wait_cnt = 2'h0;
  int n_req, n_errors = 0, checks = 0;

  always #10 i_ref_clk = ~i_ref_clk;

  rvc_if bus (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn));
  rvc_host rvc_host_i (.bus(bus), .i_start(i_start), .i_block(i_block),
    .i_key_sel(i_key_sel), .i_key(i_key), .i_persist(i_persist), .i_dest_block(i_dest_block),
    .o_busy(o_busy), .o_done(o_done), .o_result(o_result), .o_restored(o_restored));
  rvc_device rvc_device_i (.bus(bus), .i_key_we(i_key_we), .i_key_idx(i_key_idx),
    .i_key_data(i_key_data), .i_tag_done(i_tag_done), .i_tag_ok(i_tag_ok),
    .o_tag_req(o_tag_req), .o_tag_op(o_tag_op), .o_tag_block(o_tag_block),
    .o_tag_key(o_tag_key), .o_tag_key_b(o_tag_key_b));
  rvc_cmd_sva rvc_cmd_sva_i (.i_ref_clk(bus.i_ref_clk), .i_resetn(bus.i_resetn),
    .prm_we(bus.prm_we), .prm_idx(bus.prm_idx), .prm_data(bus.prm_data),
    .cmd_we(bus.cmd_we), .cmd_code(bus.cmd_code), .busy(bus.busy),
    .rsp_valid(bus.rsp_valid), .rsp_result(bus.rsp_result));

  // Tag engine: one done three cycles after each request; a chosen op may fail.
  always @(posedge i_ref_clk) begin
    i_tag_done <= (wait_cnt == 2'h1);
    i_tag_ok <= !(fail_en && o_tag_op == fail_op);
    wait_cnt <= (o_tag_req === 1'b1) ? 2'h2 : (wait_cnt != 2'h0 ? wait_cnt - 2'h1 : 2'h0);
    if (o_tag_req === 1'b1) begin
      n_req <= n_req + 1;
      ops_seen <= {ops_seen[3:0], o_tag_op};
    end
  end

  // One host job: start pulse, then a bounded wait for the done pulse.
  task automatic run_job(input logic [7:0] blk, sel, input logic [47:0] key, input logic per);
    int i;
    @(negedge i_ref_clk);
    n_req = 0;
    ops_seen = 6'h00;
    @(posedge i_ref_clk);
    {i_block, i_key_sel, i_key, i_persist, i_dest_block} <= {blk, sel, key, per, blk + 8'h01};
    i_start <= 1'b1;
    @(posedge i_ref_clk);
    i_start <= 1'b0;
    @(negedge i_ref_clk);
    `CHK(o_busy, 1'b1)
    for (i = 0; i < 300 && o_done !== 1'b1; i++) @(negedge i_ref_clk);
    `CHK(o_done, 1'b1)
    `CHK(o_busy, 1'b0)
  endtask

  // Stored key at the top index used as first sector key: auth, check, restore only.
  task automatic s_stored_key();
    @(posedge i_ref_clk);
    {i_key_we, i_key_idx, i_key_data} <= {1'b1, 6'h27, 48'hA1B2C3D4E5F6};
    @(posedge i_ref_clk);
    i_key_we <= 1'b0;
    run_job(8'h05, 8'h27, 48'h0, 1'b0);
    `CHK(o_tag_key, 48'hA1B2C3D4E5F6)
    `CHK(o_tag_key_b, 1'b0)
    `CHK(o_tag_block, 8'h05)
    `CHK({n_req, ops_seen}, {32'd3, RVC_OP_AUTH, RVC_OP_CHECK, RVC_OP_RESTORE})
    `CHK({o_result, o_restored}, {RVC_RES_OK, 1'b1})
  endtask

  // Inline key as second sector key; bytes assembled least significant first.
  task automatic s_inline_key_b();
    run_job(8'h3E, 8'hC5, 48'h665544332211, 1'b0);
    `CHK(o_tag_key, 48'h665544332211)
    `CHK(o_tag_key_b, 1'b1)
    `CHK(o_result, RVC_RES_OK)
  endtask

  // Key number one past the top is refused before any tag traffic.
  task automatic s_bad_keynum();
    run_job(8'h04, 8'h28, 48'h0, 1'b0);
    `CHK({n_req, o_result, o_restored}, {32'd0, RVC_RES_KEY_ERR, 1'b0})
  endtask

  // A failing tag step stops the sequence; no restore follows a failed check.
  task automatic s_fail_step(input rvc_tag_op_type op, input int reqs, input logic [7:0] res);
    fail_op = op;
    fail_en = 1'b1;
    run_job(8'h09, 8'hC1, 48'h0102030405AB, 1'b0);
    fail_en = 1'b0;
    `CHK({n_req, o_result, o_restored}, {reqs, res, 1'b0})
  endtask

  // Persisting needs the separate transfer command, which this device refuses.
  task automatic s_persist();
    run_job(8'h06, 8'h27, 48'h0, 1'b1);
    `CHK({n_req, o_result, o_restored}, {32'd3, RVC_RES_UNSUPP, 1'b1})
  endtask

  // Closing report, shared by the main sequence and the watchdog.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    s_stored_key();
    s_inline_key_b();
    s_bad_keynum();
    s_fail_step(RVC_OP_AUTH, 1, RVC_RES_AUTH_ERR);
    s_fail_step(RVC_OP_CHECK, 2, RVC_RES_FMT_ERR);
    s_fail_step(RVC_OP_RESTORE, 3, RVC_RES_TAG_ERR);
    s_persist();
    tally_and_finish();
  end

  // Watchdog: the jobs take a few hundred cycles, so this span means a hang.
  initial begin
    #200us;
    n_errors++;
    tally_and_finish();
  end
endmodule
